// *** core/sdos_defines.svh ***
// constants for the state driven output switch: offsets, fields, resets
// assumes a 32-bit apb register bus and a 125 MHz pclk
`ifndef SDOS_DEFINES_SVH
`define SDOS_DEFINES_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SDOS_OFF_CTRL1      12'h000
`define SDOS_OFF_CTRL2      12'h004
`define SDOS_OFF_STATUS     12'h008
`define SDOS_OFF_GTOTAL     12'h00C
`define SDOS_OFF_CMD        12'h010
`define SDOS_OFF_CODE       12'h014
`define SDOS_OFF_TSTATE     12'h018

// ****************************************************************
// output control fields
// ****************************************************************
`define SDOS_F_EN           0
`define SDOS_F_ON_SEL_LO    4
`define SDOS_F_ON_INV       7
`define SDOS_F_OFF_SEL_LO   8
`define SDOS_F_OFF_INV      11
`define SDOS_F_DLY_LO       16

// ****************************************************************
// command word fields and values
// ****************************************************************
`define SDOS_CMD_GT_CLR     2'h1
`define SDOS_CMD_DEF_RST    2'h2
`define SDOS_CONFIRM_WORD   16'h5E5E

// ****************************************************************
// reset values and limits
// ****************************************************************
`define SDOS_CTRL_RESET     32'h0000_0000
`define SDOS_CODE_RESET     16'h0000
`define SDOS_DLY_MAX        15'h7E90
`define SDOS_TICK_SECONDS   1
`define SDOS_CLK_HZ         125000000
`define SDOS_TICK_CYCLES    (`SDOS_TICK_SECONDS * `SDOS_CLK_HZ)

`endif

// *** core/sdos_pkg.sv ***
// types shared by the state driven output switch
// assumes the defines header is included by each user
package sdos_pkg;

    typedef enum logic [2:0]
    {
        SDOS_ST_CLEARED = 3'h0,
        SDOS_ST_RUNNING = 3'h1,
        SDOS_ST_HALTED  = 3'h2,
        SDOS_ST_RESTART = 3'h3,
        SDOS_ST_DONE    = 3'h4
    } sdos_tstate_t;

    typedef struct packed
    {
        logic [14:0]  delay;
        logic         off_inv;
        logic [2:0]   off_sel;
        logic         on_inv;
        logic [2:0]   on_sel;
        logic         enable;
    } sdos_cfg_t;

    typedef enum logic [1:0]
    {
        SDOS_SW_OPEN    = 2'b00,
        SDOS_SW_WAIT    = 2'b01,
        SDOS_SW_CLOSED  = 2'b11
    } sdos_sw_t;

endpackage

// *** core/sdos_tick.sv ***
// one-second tick generator
// assumes pclk at the rate in the defines header
`timescale 1ns/10ps
`include "sdos_defines.svh"

module sdos_tick
#(
    parameter int TICK_CYCLES = `SDOS_TICK_CYCLES
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    if (TICK_CYCLES < 2)
    begin : g_period_chk
        $error("tick period too short");
    end

    logic [31:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b0;
        end
        else if (cnt_r == 32'(TICK_CYCLES - 1))
        begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule

// *** core/sdos_switch.sv ***
// one switch channel: state match on the entry strobe, on-delay and open/closed state
// assumes a one-cycle state-entry strobe and a one-cycle second tick
`timescale 1ns/10ps
`include "sdos_defines.svh"

module sdos_switch
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire sdos_pkg::sdos_cfg_t cfg,
    input  wire sdos_pkg::sdos_tstate_t tstate,
    input  wire logic               enter,
    input  wire logic               tick,
    output logic                    closed
);
    sdos_pkg::sdos_sw_t st_r;
    logic [14:0]        dly_r;
    logic               on_hit;
    logic               off_hit;

    // an inverted selection fires on entry to any other state
    assign on_hit  = enter &&
        ((tstate == sdos_pkg::sdos_tstate_t'(cfg.on_sel)) ^ cfg.on_inv);
    assign off_hit = enter &&
        ((tstate == sdos_pkg::sdos_tstate_t'(cfg.off_sel)) ^ cfg.off_inv);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r  <= sdos_pkg::SDOS_SW_OPEN;
            dly_r <= 15'h0000;
        end
        else if (!cfg.enable)
            st_r <= sdos_pkg::SDOS_SW_OPEN;
        else
        begin
            case (st_r)
                sdos_pkg::SDOS_SW_OPEN:
                begin
                    if (on_hit && !off_hit)
                    begin
                        dly_r <= cfg.delay;
                        st_r  <= (cfg.delay == 15'h0000) ?
                            sdos_pkg::SDOS_SW_CLOSED :
                            sdos_pkg::SDOS_SW_WAIT;
                    end
                end
                sdos_pkg::SDOS_SW_WAIT:
                begin
                    if (off_hit)
                        st_r <= sdos_pkg::SDOS_SW_OPEN;
                    else if (tick)
                    begin
                        dly_r <= dly_r - 15'h0001;
                        if (dly_r == 15'h0001)
                            st_r <= sdos_pkg::SDOS_SW_CLOSED;
                    end
                end
                sdos_pkg::SDOS_SW_CLOSED:
                begin
                    if (off_hit)
                        st_r <= sdos_pkg::SDOS_SW_OPEN;
                end
                default:
                    st_r <= sdos_pkg::SDOS_SW_OPEN;
            endcase
        end
    end

    assign closed = (st_r == sdos_pkg::SDOS_SW_CLOSED);
endmodule

// *** core/sdos_top.sv ***
// state driven output switch: two switch outputs with apb configuration
// assumes timer state arrives from logic on pclk, valid every cycle
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "sdos_defines.svh"

module sdos_top
#(
    parameter int TICK_CYCLES = `SDOS_TICK_CYCLES
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    input  wire sdos_pkg::sdos_tstate_t timer_state,
    input  wire logic               display_mode,
    output logic                    switch_output_1,
    output logic                    second_switch_output,
    output logic                    indicator_1,
    output logic                    indicator_2,
    output logic                    config_locked,
    output logic                    display_return_req
);
    // refused at elaboration: a period under two cycles would hold the
    // tick high for good and count every cycle as a second
    if (TICK_CYCLES < 2)
    begin : g_tick_chk
        $error("TICK_CYCLES must be at least 2");
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // ****************************************************************
    // configuration storage
    // ****************************************************************
    sdos_pkg::sdos_cfg_t cfg1_r;
    sdos_pkg::sdos_cfg_t cfg2_r;
    logic [15:0]         code_pend_r;
    logic [15:0]         code_act_r;
    logic [31:0]         gtotal_r;
    logic                cmd_gt_clr;
    logic                cmd_def_rst;
    logic                bad_dly;

    // a command without the confirmation word is dropped without error
    assign cmd_gt_clr  = wr_en && paddr == `SDOS_OFF_CMD &&
                         pwdata[31:16] == `SDOS_CONFIRM_WORD &&
                         pwdata[1:0] == `SDOS_CMD_GT_CLR;
    assign cmd_def_rst = wr_en && paddr == `SDOS_OFF_CMD &&
                         pwdata[31:16] == `SDOS_CONFIRM_WORD &&
                         pwdata[1:0] == `SDOS_CMD_DEF_RST;
    // delays beyond the documented maximum are refused with an error
    assign bad_dly = pwdata[30:16] > `SDOS_DLY_MAX;

    function automatic sdos_pkg::sdos_cfg_t to_cfg(input logic [31:0] w);
        sdos_pkg::sdos_cfg_t c;
        c.enable  = w[`SDOS_F_EN];
        c.on_sel  = w[`SDOS_F_ON_SEL_LO +: 3];
        c.on_inv  = w[`SDOS_F_ON_INV];
        c.off_sel = w[`SDOS_F_OFF_SEL_LO +: 3];
        c.off_inv = w[`SDOS_F_OFF_INV];
        c.delay   = w[`SDOS_F_DLY_LO +: 15];
        return c;
    endfunction

    function automatic logic [31:0] from_cfg(input sdos_pkg::sdos_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`SDOS_F_EN]             = c.enable;
        w[`SDOS_F_ON_SEL_LO +: 3] = c.on_sel;
        w[`SDOS_F_ON_INV]         = c.on_inv;
        w[`SDOS_F_OFF_SEL_LO +: 3] = c.off_sel;
        w[`SDOS_F_OFF_INV]        = c.off_inv;
        w[`SDOS_F_DLY_LO +: 15]   = c.delay;
        return w;
    endfunction

    // each write replaces one output's whole word, so toggling enable
    // only rewrites the enable bit when software keeps the rest
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg1_r <= sdos_pkg::sdos_cfg_t'(`SDOS_CTRL_RESET);
            cfg2_r <= sdos_pkg::sdos_cfg_t'(`SDOS_CTRL_RESET);
        end
        else if (cmd_def_rst)
        begin
            cfg1_r <= sdos_pkg::sdos_cfg_t'(`SDOS_CTRL_RESET);
            cfg2_r <= sdos_pkg::sdos_cfg_t'(`SDOS_CTRL_RESET);
        end
        else if (wr_en && !bad_dly)
        begin
            if (paddr == `SDOS_OFF_CTRL1)
                cfg1_r <= to_cfg(pwdata);
            if (paddr == `SDOS_OFF_CTRL2)
                cfg2_r <= to_cfg(pwdata);
        end
    end

    // ****************************************************************
    // access code
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_pend_r <= `SDOS_CODE_RESET;
            code_act_r  <= `SDOS_CODE_RESET;
        end
        else
        begin
            if (cmd_def_rst)
                code_pend_r <= `SDOS_CODE_RESET;
            else if (wr_en && paddr == `SDOS_OFF_CODE)
                code_pend_r <= pwdata[15:0];
            // the new code only guards the menu after the display returns
            if (display_mode || cmd_def_rst)
                code_act_r <= cmd_def_rst ? `SDOS_CODE_RESET
                                          : code_pend_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            config_locked <= 1'b0;
        else
            config_locked <= (code_act_r != `SDOS_CODE_RESET);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            display_return_req <= 1'b0;
        else
            display_return_req <= cmd_def_rst;
    end

    // ****************************************************************
    // state entry detect and second tick
    // ****************************************************************
    sdos_pkg::sdos_tstate_t prev_r;
    logic                   prev_vld_r;
    logic                   enter;
    logic                   tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r     <= sdos_pkg::SDOS_ST_CLEARED;
            prev_vld_r <= 1'b0;
        end
        else
        begin
            prev_r     <= timer_state;
            prev_vld_r <= 1'b1;
        end
    end

    // the first state after reset counts as an entry
    assign enter = !prev_vld_r || (timer_state != prev_r);

    sdos_tick
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_tick
    (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // ****************************************************************
    // grand total
    // ****************************************************************
    // saturates rather than wrap, so a full total is never shown small
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gtotal_r <= 32'h0000_0000;
        // the clear cannot be undone: no copy of the old total is kept
        else if (cmd_gt_clr)
            gtotal_r <= 32'h0000_0000;
        else if (tick && timer_state == sdos_pkg::SDOS_ST_RUNNING &&
                 gtotal_r != 32'hFFFF_FFFF)
            gtotal_r <= gtotal_r + 32'h0000_0001;
    end

    // ****************************************************************
    // switch channels
    // ****************************************************************
    logic [1:0]          sw_closed;
    sdos_pkg::sdos_cfg_t cfg_arr [2];
    assign cfg_arr[0] = cfg1_r;
    assign cfg_arr[1] = cfg2_r;

    // both channels share one entry strobe and tick, so they stay in step
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sw
            sdos_switch u_sw
            (
                .pclk    (pclk),
                .presetn (presetn),
                .cfg     (cfg_arr[gi]),
                .tstate  (timer_state),
                .enter   (enter),
                .tick    (tick),
                .closed  (sw_closed[gi])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            switch_output_1      <= 1'b0;
            second_switch_output <= 1'b0;
            indicator_1          <= 1'b0;
            indicator_2          <= 1'b0;
        end
        else
        begin
            switch_output_1      <= sw_closed[0];
            second_switch_output <= sw_closed[1];
            indicator_1          <= sw_closed[0];
            indicator_2          <= sw_closed[1];
        end
    end

    // ****************************************************************
    // apb answer: zero wait states
    // ****************************************************************
    // ready is raised by the setup cycle, so every access is wait-free;
    // writes land at the access edge through wr_en
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                case (paddr)
                    `SDOS_OFF_CTRL1:  prdata <= from_cfg(cfg1_r);
                    `SDOS_OFF_CTRL2:  prdata <= from_cfg(cfg2_r);
                    `SDOS_OFF_STATUS: prdata <= {30'h0, sw_closed};
                    `SDOS_OFF_GTOTAL: prdata <= gtotal_r;
                    `SDOS_OFF_CMD:    prdata <= 32'h0000_0000;
                    `SDOS_OFF_CODE:   prdata <= {16'h0, code_pend_r};
                    `SDOS_OFF_TSTATE: prdata <= {29'h0, timer_state};
                    default:          pslverr <= 1'b1;
                endcase
                if (pwrite && (paddr == `SDOS_OFF_CTRL1 ||
                               paddr == `SDOS_OFF_CTRL2) && bad_dly)
                    pslverr <= 1'b1;
            end
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

// *** test/sdos_top_asserts.sv ***
// port-level checker for the state driven output switch
// assumes it is bound to sdos_top and sees only its ports
`timescale 1ns/10ps
`include "sdos_defines.svh"
module sdos_chk
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [31:0]            prdata,
    input wire sdos_pkg::sdos_tstate_t timer_state,
    input wire logic                   display_mode,
    input wire logic                   switch_output_1,
    input wire logic                   second_switch_output,
    input wire logic                   indicator_1,
    input wire logic                   indicator_2,
    input wire logic                   config_locked,
    input wire logic                   display_return_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
// ********
// checks
// ********
    property p_ind1;
        indicator_1 == switch_output_1;
    endproperty
    a_ind1: assert property (p_ind1)
        else $error("indicator 1 differs from output 1");
    property p_ind2;
        indicator_2 == second_switch_output;
    endproperty
    a_ind2: assert property (p_ind2)
        else $error("indicator 2 differs from output 2");
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("no answer after setup");
    property p_rdy_only;
        pready |-> psel && penable;
    endproperty
    a_rdy_only: assert property (p_rdy_only)
        else $error("ready outside an access");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err)
        else $error("error without ready");
    property p_ret;
        display_return_req |=> !display_return_req;
    endproperty
    a_ret: assert property (p_ret)
        else $error("display return longer than a cycle");
    property p_lock;
        $rose(config_locked) |-> $past(display_mode)
            || $past(display_mode, 2);
    endproperty
    a_lock: assert property (p_lock)
        else $error("code activated outside display mode");
    property p_dis;
        psel && penable && pwrite && paddr == `SDOS_OFF_CTRL1
            && !pwdata[0] && pwdata[30:16] <= `SDOS_DLY_MAX
            |-> ##[1:3] !switch_output_1;
    endproperty
    a_dis: assert property (p_dis)
        else $error("disabled output not opened");
    property p_stat;
        psel && !penable && !pwrite && paddr == `SDOS_OFF_STATUS
            |=> prdata[1:0] == {second_switch_output, switch_output_1};
    endproperty
    a_stat: assert property (p_stat)
        else $error("status read differs from outputs");
endmodule
bind sdos_top sdos_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .timer_state(timer_state),
    .display_mode(display_mode), .switch_output_1(switch_output_1),
    .second_switch_output(second_switch_output),
    .indicator_1(indicator_1), .indicator_2(indicator_2),
    .config_locked(config_locked),
    .display_return_req(display_return_req)
);

// *** test/sdos_load.sv ***
// model of the loads switched by the two contacts
// assumes contact high means closed; counts each closure
`timescale 1ns/10ps
module sdos_load
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic contact_a,
    input wire logic contact_b,
    output int       closures_a,
    output int       closures_b
);
    logic a_r;
    logic b_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_r <= 1'b0;
            b_r <= 1'b0;
            closures_a <= 0;
            closures_b <= 0;
        end
        else
        begin
            a_r <= contact_a;
            b_r <= contact_b;
            closures_a <= closures_a + int'(contact_a && !a_r);
            closures_b <= closures_b + int'(contact_b && !b_r);
        end
    end
endmodule

// *** test/test_state_driven_output_switch.sv ***
// self-checking bench for the state driven output switch
// assumes a 10-cycle second tick so delays stay short
`timescale 1ns/10ps
`include "sdos_defines.svh"
module test_state_driven_output_switch;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, g;
    logic pready, pslverr, so1, so2, ind1, ind2, lock, dret;
    logic dmode = 0, ret_seen = 0;
    sdos_pkg::sdos_tstate_t tst = sdos_pkg::SDOS_ST_CLEARED;
    int bad_count = 0, checked = 0, ca, cb, n;
    sdos_top #(.TICK_CYCLES(10)) dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .timer_state(tst),
        .display_mode(dmode), .switch_output_1(so1),
        .second_switch_output(so2), .indicator_1(ind1),
        .indicator_2(ind2), .config_locked(lock),
        .display_return_req(dret)
    );
    sdos_load u_load
    (
        .pclk(pclk), .presetn(presetn), .contact_a(so1), .contact_b(so2),
        .closures_a(ca), .closures_b(cb)
    );
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
        if (dret === 1'b1) ret_seen <= 1'b1;
// ********
// shared tasks
// ********
    task automatic tally_and_finish;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, q);
        checked++;
        if (q !== e)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, q);
        end
    endtask
    // released one edge before the next setup, so no double drive
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // values read here are those sampled at this edge
        while (pready !== 1'b1)
        begin
            if (k++ == 20)
            begin
                bad_count++;
                tally_and_finish();
            end
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk("write pslverr", {31'h0, ee}, {31'h0, e});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("read pslverr", {31'h0, ee}, {31'h0, e});
        if (!ee) chk("prdata", x, q);
    endtask
    task automatic go(input logic [2:0] s);
        @(posedge pclk);
        tst <= sdos_pkg::sdos_tstate_t'(s);
        repeat (4) @(posedge pclk);
        #1;
    endtask
    task automatic sw(input logic a, b);
        chk("switch_output_1", {31'h0, a}, {31'h0, so1});
        chk("second_switch_output", {31'h0, b}, {31'h0, so2});
        chk("indicator_1", {31'h0, a}, {31'h0, ind1});
        chk("indicator_2", {31'h0, b}, {31'h0, ind2});
    endtask
    function automatic logic [31:0] cw(input logic en, input logic [2:0] on,
        input logic oi, input logic [2:0] of, input logic fi,
        input logic [14:0] d);
        return {1'b0, d, 4'h0, fi, of, oi, on, 3'h0, en};
    endfunction
// ********
// scenarios
// ********
    task automatic t_reset;
        rd(`SDOS_OFF_CTRL1, 32'h0, 1'b0);
        rd(`SDOS_OFF_CTRL2, 32'h0, 1'b0);
        rd(`SDOS_OFF_STATUS, 32'h0, 1'b0);
        rd(`SDOS_OFF_CODE, 32'h0, 1'b0);
        rd(12'h01C, 32'h0, 1'b1);
        chk("config_locked", 32'h0, {31'h0, lock});
    endtask
    task automatic t_states;
        for (int s = 0; s < 5; s++)
        begin
            logic [2:0] a, x;
            a = 3'(s);
            x = 3'((s + 1) % 5);
            wr(`SDOS_OFF_CTRL1, cw(1, a, 0, x, 0, 0), 1'b0);
            go(x);
            sw(0, 0);
            go(a);
            sw(1, 0);
            go(x);
            sw(0, 0);
            wr(`SDOS_OFF_CTRL1, cw(1, x, 1, a, 1, 0), 1'b0);
            go(a);
            sw(1, 0);
            go(x);
            sw(0, 0);
        end
        chk("closures", 32'd10, ca);
    endtask
    task automatic t_delay;
        wr(`SDOS_OFF_CTRL1, 32'h0, 1'b0);
        wr(`SDOS_OFF_CTRL2, cw(1, 1, 0, 4, 0, 3), 1'b0);
        @(posedge pclk);
        tst <= sdos_pkg::SDOS_ST_RUNNING;
        n = 0;
        #1;
        while (so2 !== 1'b1 && n < 60)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("on delay window", 1, {31'h0, n >= 18 && n <= 34});
        chk("indicator_2", 1, {31'h0, ind2});
        go(3'h4);
        sw(0, 0);
        go(3'h1);
        go(3'h4);
        repeat (40) @(posedge pclk);
        #1;
        sw(0, 0);
        wr(`SDOS_OFF_CTRL2, cw(1, 1, 0, 4, 0, 15'h7E90), 1'b0);
        wr(`SDOS_OFF_CTRL2, cw(1, 1, 0, 4, 0, 15'h7E91), 1'b1);
        rd(`SDOS_OFF_CTRL2, cw(1, 1, 0, 4, 0, 15'h7E90), 1'b0);
    endtask
    task automatic t_enable;
        wr(`SDOS_OFF_CTRL1, cw(1, 1, 0, 4, 0, 0), 1'b0);
        go(3'h1);
        go(3'h2);
        sw(1, 0);
        wr(`SDOS_OFF_CTRL1, cw(0, 1, 0, 4, 0, 0), 1'b0);
        repeat (3) @(posedge pclk);
        #1;
        sw(0, 0);
        rd(`SDOS_OFF_CTRL1, cw(0, 1, 0, 4, 0, 0), 1'b0);
    endtask
    task automatic t_total;
        logic e;
        go(3'h1);
        repeat (30) @(posedge pclk);
        go(3'h2);
        apb(1'b0, `SDOS_OFF_GTOTAL, 32'h0, g, e);
        chk("total counts", 1, {31'h0, g != 0});
        wr(`SDOS_OFF_CMD, 32'h1234_0001, 1'b0);
        rd(`SDOS_OFF_GTOTAL, g, 1'b0);
        wr(`SDOS_OFF_CMD, {`SDOS_CONFIRM_WORD, 14'h0, `SDOS_CMD_GT_CLR}, 0);
        rd(`SDOS_OFF_GTOTAL, 32'h0, 1'b0);
        go(3'h1);
        repeat (30) @(posedge pclk);
        go(3'h2);
        apb(1'b0, `SDOS_OFF_GTOTAL, 32'h0, g, e);
        chk("total recount", 1, {31'h0, g != 0});
    endtask
    task automatic t_code;
        wr(`SDOS_OFF_CODE, 32'h0000_1234, 1'b0);
        repeat (4) @(posedge pclk);
        chk("lock pending", 32'h0, {31'h0, lock});
        dmode <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("lock active", 32'h1, {31'h0, lock});
        dmode <= 1'b0;
        wr(`SDOS_OFF_CMD, {`SDOS_CONFIRM_WORD, 14'h0, `SDOS_CMD_DEF_RST}, 0);
        repeat (4) @(posedge pclk);
        chk("display return", 32'h1, {31'h0, ret_seen});
        rd(`SDOS_OFF_CTRL2, 32'h0, 1'b0);
        rd(`SDOS_OFF_GTOTAL, g, 1'b0);
        dmode <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("lock default", 32'h0, {31'h0, lock});
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_states();
        t_delay();
        t_enable();
        t_total();
        t_code();
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
endmodule
